// file: cfs_pkg.sv
// Shared constants for the channel fault status block
package cfs_pkg;
    localparam int CFS_UNITS = 8;
    localparam int CFS_SLOTS = 16;
    localparam int CFS_ADDR_W = 8;
    localparam int CFS_LOG_W = 8;
    // Register byte offsets
    localparam logic [7:0] CFS_CTRL_OFF = 8'h00;
    localparam logic [7:0] CFS_STATUS_OFF = 8'h04;
    localparam logic [7:0] CFS_EVENT_OFF = 8'h08;
    localparam logic [7:0] CFS_LOG_OFF = 8'h0C;
    localparam logic [7:0] CFS_SLOT_BASE = 8'h10;
    localparam logic [7:0] CFS_SLOT_LAST = 8'h2C;
    localparam logic [7:0] CFS_ACCESS_OFF = 8'h30;
    // Control fields
    localparam int CFS_CTRL_IO_STOP = 0;
    localparam int CFS_CTRL_SUB_STOP = 1;
    localparam logic [1:0] CFS_CTRL_RST = 2'h0;
    // Status fields
    localparam int CFS_ST_HEALTHY = 0;
    localparam int CFS_ST_COMM = 1;
    localparam int CFS_ST_SWITCH = 2;
    localparam int CFS_ST_EST = 3;
    localparam int CFS_ST_ERR = 4;
    localparam int CFS_ST_ALM = 5;
    // Event fields
    localparam int CFS_EV_COMM = 0;
    localparam int CFS_EV_SWITCH = 1;
    // Log kinds, held in bits 9:8 of the log register
    localparam int CFS_LOG_KIND_LSB = 8;
    localparam logic [1:0] CFS_KIND_NONE = 2'h0;
    localparam logic [1:0] CFS_KIND_COMM = 2'h1;
    localparam logic [1:0] CFS_KIND_SWITCH = 2'h2;
    // Bus answers
    localparam logic [1:0] CFS_RESP_OKAY = 2'h0;
    localparam logic [1:0] CFS_RESP_SLVERR = 2'h2;
endpackage : cfs_pkg

// file: cfs_unit_if.sv
// Per-unit link signals between the core and a unit status slice
`timescale 1ns/1ps
`default_nettype none
interface cfs_unit_if;
    logic established;
    logic [15:0] slot_fault;
    logic port_a_err;
    logic port_b_err;
    logic ready;
    logic [15:0] slots;
    logic ind_a;
    logic ind_b;
    logic ind_rdy;
    modport core (output established, slot_fault, port_a_err, port_b_err,
        ready, input slots, ind_a, ind_b, ind_rdy);
    modport unit (input established, slot_fault, port_a_err, port_b_err,
        ready, output slots, ind_a, ind_b, ind_rdy);
endinterface : cfs_unit_if
`default_nettype wire

// file: cfs_unit_status.sv
// Slot bitmap and port indicators for one unit
`timescale 1ns/1ps
`default_nettype none
module cfs_unit_status
    import cfs_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    cfs_unit_if.unit u
);
    logic [15:0] slots;
    logic ind_a;
    logic ind_b;
    logic ind_rdy;
    logic [15:0] next_slots;
    logic next_ind_a;
    logic next_ind_b;
    logic next_ind_rdy;

    // Bitmap stays clear until the channel has been normal once
    always_comb begin
        next_slots = u.established ? u.slot_fault : 16'h0000;
        next_ind_a = u.port_a_err;
        next_ind_b = u.port_b_err;
        next_ind_rdy = u.ready;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            slots <= 16'h0000;
            ind_a <= 1'b0;
            ind_b <= 1'b0;
            ind_rdy <= 1'b0;
        end else begin
            slots <= next_slots;
            ind_a <= next_ind_a;
            ind_b <= next_ind_b;
            ind_rdy <= next_ind_rdy;
        end
    end

    assign u.slots = slots;
    assign u.ind_a = ind_a;
    assign u.ind_b = ind_b;
    assign u.ind_rdy = ind_rdy;
endmodule // cfs_unit_status
`default_nettype wire

// file: cfs_channel_fault_status.sv
// Channel fault status core with its AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Channel or link fault lights error or alarm
// - Both run: alarm only; any stop: error
// - Other module faults drive the same indicators
// - Ready and per-port fault indicators per unit
// - Loop switchover: alarm only, keep running
// - Comm faults and loop switchovers, once established, logged and notified
// - Comm fault blocks unreachable subunit access
// - Switchover keeps all subunits accessible
// - Healthy flag only while channel normal
// - Comm fault flag only after once normal
// - Switch flag only after once normal
// - Track established since power-on
// - Per-unit slot bitmaps of faulting link modules
module cfs_channel_fault_status
    import cfs_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic loop_topology,
    input wire logic chan_comm_lost,
    input wire logic chan_primary_break,
    input wire logic other_module_fault,
    input wire logic [127:0] link_slot_fault,
    input wire logic [7:0] link_port_a_err,
    input wire logic [7:0] link_port_b_err,
    input wire logic [7:0] link_ready,
    input wire logic [7:1] subunit_unreachable,
    output logic cpu_error_indicator,
    output logic cpu_alarm_indicator,
    output logic line_healthy_flag,
    output logic comm_fault_flag,
    output logic loop_switched_flag,
    output logic notify_comm_fault,
    output logic notify_switchover,
    output logic [7:1] subunit_access_enable,
    output wire logic [7:0] port_a_fault_indicator,
    output wire logic [7:0] port_b_fault_indicator,
    output wire logic [7:0] link_ready_indicator
);
    // Core state
    logic established;
    logic [1:0] ctrl;
    logic [1:0] events;
    logic [CFS_LOG_W-1:0] log_count;
    logic [1:0] log_kind;
    logic next_established;
    logic next_error;
    logic next_alarm;
    logic next_healthy;
    logic next_comm;
    logic next_switch;
    logic next_note_comm;
    logic next_note_switch;
    logic [7:1] next_access;
    logic [1:0] next_ctrl;
    logic [1:0] next_events;
    logic [CFS_LOG_W-1:0] next_log_count;
    logic [1:0] next_log_kind;
    // Bus state
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held;
    logic next_w_held;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    // Helpers
    logic chan_normal;
    logic chan_switched;
    logic fault_any;
    logic stop_cfg;
    logic slot_any;
    logic wr_fire;
    logic ctrl_wr;
    logic event_wr;
    logic [1:0] ev_rise;
    logic [7:0] slot_off;
    wire logic [15:0] unit_slots [CFS_UNITS];
    wire logic [CFS_UNITS-1:0] unit_slot_any;

    // One slice per unit keeps bitmaps and port lamps
    genvar gu;
    generate
        for (gu = 0; gu < CFS_UNITS; gu++) begin : g_unit
            cfs_unit_if uif ();
            assign uif.established = established;
            assign uif.slot_fault = link_slot_fault[gu*16 +: 16];
            assign uif.port_a_err = link_port_a_err[gu];
            assign uif.port_b_err = link_port_b_err[gu];
            assign uif.ready = link_ready[gu];
            assign unit_slots[gu] = uif.slots;
            assign unit_slot_any[gu] = |uif.slots;
            assign port_a_fault_indicator[gu] = uif.ind_a;
            assign port_b_fault_indicator[gu] = uif.ind_b;
            assign link_ready_indicator[gu] = uif.ind_rdy;
            cfs_unit_status u_slice (
                .clk(clk),
                .arst_n(arst_n),
                .u(uif.unit)
            );
        end
    endgenerate

    // Channel classification; a daisy chain has no second loop to use
    assign chan_switched = loop_topology & chan_primary_break
        & ~chan_comm_lost;
    assign chan_normal = ~chan_comm_lost & ~chan_primary_break;
    assign slot_any = |unit_slot_any;
    assign stop_cfg = ctrl[CFS_CTRL_IO_STOP] | ctrl[CFS_CTRL_SUB_STOP];
    assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
    assign ctrl_wr = wr_fire & (aw_addr == CFS_CTRL_OFF) & w_strb[0];
    assign event_wr = wr_fire & (aw_addr == CFS_EVENT_OFF) & w_strb[0];
    // Bitmap window does not start at zero, so index from its base
    assign slot_off = s_axi_araddr - CFS_SLOT_BASE;

    // Flags, lamps, events and log
    always_comb begin
        next_established = established | chan_normal;
        next_healthy = chan_normal;
        next_comm = established & chan_comm_lost;
        next_switch = established & chan_switched;
        // A switchover alone is not a stop-class fault
        fault_any = next_comm | other_module_fault
            | (slot_any & ~chan_switched);
        next_error = fault_any & stop_cfg;
        next_alarm = (fault_any & ~stop_cfg) | next_switch;
        ev_rise[CFS_EV_COMM] = next_comm & ~comm_fault_flag;
        ev_rise[CFS_EV_SWITCH] = next_switch & ~loop_switched_flag;
        next_note_comm = ev_rise[CFS_EV_COMM];
        next_note_switch = ev_rise[CFS_EV_SWITCH];
        // Switchover leaves every subunit reachable
        next_access = ~({7{next_comm}} & subunit_unreachable);
        // Held copy, since the master may drop wdata once it is taken
        next_ctrl = ctrl_wr ? w_data[1:0] : ctrl;
        // Set wins over a clear in the same cycle
        next_events = events;
        if (event_wr) begin
            next_events = events & ~w_data[1:0];
        end
        next_events = next_events | ev_rise;
        next_log_count = log_count;
        next_log_kind = log_kind;
        if (|ev_rise) begin
            // Count saturates rather than wrapping to zero
            if (log_count != {CFS_LOG_W{1'b1}}) begin
                next_log_count = log_count + 8'h01;
            end
            next_log_kind = ev_rise[CFS_EV_COMM] ? CFS_KIND_COMM
                : CFS_KIND_SWITCH;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            established <= 1'b0;
            line_healthy_flag <= 1'b0;
            comm_fault_flag <= 1'b0;
            loop_switched_flag <= 1'b0;
            cpu_error_indicator <= 1'b0;
            cpu_alarm_indicator <= 1'b0;
            notify_comm_fault <= 1'b0;
            notify_switchover <= 1'b0;
            subunit_access_enable <= 7'h7F;
            ctrl <= CFS_CTRL_RST;
            events <= 2'h0;
            log_count <= 8'h00;
            log_kind <= CFS_KIND_NONE;
        end else begin
            established <= next_established;
            line_healthy_flag <= next_healthy;
            comm_fault_flag <= next_comm;
            loop_switched_flag <= next_switch;
            cpu_error_indicator <= next_error;
            cpu_alarm_indicator <= next_alarm;
            notify_comm_fault <= next_note_comm;
            notify_switchover <= next_note_switch;
            subunit_access_enable <= next_access;
            ctrl <= next_ctrl;
            events <= next_events;
            log_count <= next_log_count;
            log_kind <= next_log_kind;
        end
    end

    // Write channel: address and data taken in either order
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        if (s_axi_awvalid & s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            // Read-only registers accept writes silently
            next_bresp = (aw_addr <= CFS_ACCESS_OFF && aw_addr[1:0] == 2'h0)
                ? CFS_RESP_OKAY : CFS_RESP_SLVERR;
        end else if (s_axi_bvalid & s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        next_awready = ~next_aw_held & ~next_bvalid;
        next_wready = ~next_w_held & ~next_bvalid;
    end

    // Read channel: one read outstanding at a time
    always_comb begin
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid & s_axi_arready) begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = CFS_RESP_OKAY;
            next_rdata = 32'h0000_0000;
            if (s_axi_araddr[1:0] != 2'h0) begin
                next_rresp = CFS_RESP_SLVERR;
            end else if (s_axi_araddr >= CFS_SLOT_BASE
                    && s_axi_araddr <= CFS_SLOT_LAST) begin
                next_rdata[15:0] = unit_slots[slot_off[4:2]];
            end else begin
                case (s_axi_araddr)
                    CFS_CTRL_OFF: next_rdata[1:0] = ctrl;
                    CFS_STATUS_OFF: next_rdata[5:0] = {cpu_alarm_indicator,
                        cpu_error_indicator, established, loop_switched_flag,
                        comm_fault_flag, line_healthy_flag};
                    CFS_EVENT_OFF: next_rdata[1:0] = events;
                    CFS_LOG_OFF: next_rdata[9:0] = {log_kind, log_count};
                    CFS_ACCESS_OFF: next_rdata[7:1] = subunit_access_enable;
                    default: next_rresp = CFS_RESP_SLVERR;
                endcase
            end
        end else if (s_axi_rvalid & s_axi_rready) begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
        // Ready rises one edge after reset release
        if (!s_axi_arready && !s_axi_rvalid) begin
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end
endmodule // cfs_channel_fault_status
`default_nettype wire

// file: cfs_checker.sv
// Port-level assertions for the channel fault status block
`timescale 1ns/1ps
`default_nettype none
module cfs_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic loop_topology,
    input wire logic chan_comm_lost,
    input wire logic chan_primary_break,
    input wire logic other_module_fault,
    input wire logic [7:0] link_port_a_err,
    input wire logic [7:0] link_ready,
    input wire logic cpu_error_indicator,
    input wire logic cpu_alarm_indicator,
    input wire logic line_healthy_flag,
    input wire logic comm_fault_flag,
    input wire logic loop_switched_flag,
    input wire logic notify_comm_fault,
    input wire logic notify_switchover,
    input wire logic [7:1] subunit_access_enable,
    input wire logic [7:0] port_a_fault_indicator,
    input wire logic [7:0] link_ready_indicator
);
    logic run;
    logic seen;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Guard hides the first edge, where past values still date from reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run <= 1'b0;
            seen <= 1'b0;
        end else begin
            run <= 1'b1;
            seen <= seen | line_healthy_flag;
        end
    end
    // Two samples in a row, so lamp latency choices cannot matter
    sequence s_comm2;
        comm_fault_flag [*2];
    endsequence
    sequence s_sw2;
        loop_switched_flag [*2];
    endsequence
    property p_lamp;
        s_comm2 |-> cpu_error_indicator || cpu_alarm_indicator;
    endproperty
    a_lamp: assert property (p_lamp)
        else $error("no lamp during comm fault");
    property p_other;
        run && $past(other_module_fault) |->
            cpu_error_indicator || cpu_alarm_indicator;
    endproperty
    a_other: assert property (p_other)
        else $error("no lamp for other module fault");
    property p_ind;
        run |-> port_a_fault_indicator == $past(link_port_a_err) &&
            link_ready_indicator == $past(link_ready);
    endproperty
    a_ind: assert property (p_ind)
        else $error("unit indicator not following link");
    property p_swalm;
        s_sw2 |-> cpu_alarm_indicator;
    endproperty
    a_swalm: assert property (p_swalm)
        else $error("switchover without alarm");
    property p_access;
        s_sw2 |-> subunit_access_enable == 7'h7F;
    endproperty
    a_access: assert property (p_access)
        else $error("subunit blocked during switchover");
    property p_healthy;
        run |-> line_healthy_flag ==
            $past(!chan_comm_lost && !chan_primary_break);
    endproperty
    a_healthy: assert property (p_healthy)
        else $error("healthy flag wrong");
    property p_comm;
        comm_fault_flag |-> !line_healthy_flag && $past(chan_comm_lost);
    endproperty
    a_comm: assert property (p_comm)
        else $error("comm flag without fault");
    property p_sw;
        loop_switched_flag |-> $past(loop_topology && chan_primary_break
            && !chan_comm_lost);
    endproperty
    a_sw: assert property (p_sw)
        else $error("switch flag without loop break");
    property p_est;
        comm_fault_flag || loop_switched_flag |-> seen;
    endproperty
    a_est: assert property (p_est)
        else $error("fault flag before channel established");
    property p_note;
        run |-> notify_comm_fault == $rose(comm_fault_flag);
    endproperty
    a_note: assert property (p_note)
        else $error("notify pulse not on flag rise");
    property p_note_sw;
        run |-> notify_switchover == $rose(loop_switched_flag);
    endproperty
    a_note_sw: assert property (p_note_sw)
        else $error("switch notify pulse not on flag rise");
endmodule // cfs_checker
bind cfs_channel_fault_status cfs_checker u_chk (.*);
`default_nettype wire

// file: cfs_link_model.sv
// Behavioural far-side link modules for the status bench
`timescale 1ns/1ps
`default_nettype none
module cfs_link_model (
    input wire logic clk,
    input wire logic [2:0] scen,
    output logic loop_topology,
    output logic chan_comm_lost,
    output logic chan_primary_break,
    output logic [127:0] link_slot_fault,
    output logic [7:0] link_port_a_err,
    output logic [7:0] link_port_b_err,
    output logic [7:0] link_ready,
    output logic [7:1] subunit_unreachable
);
    // Bit 0 loses subunits 3..7, bit 1 breaks the primary loop, bit 2
    // selects loop cabling; no reset, so a fault can outlast one
    always_ff @(posedge clk) begin
        loop_topology <= scen[2];
        chan_comm_lost <= scen[0];
        chan_primary_break <= scen[1];
        link_slot_fault <= scen[0] ? 128'h20_0000_0000 : 128'h0;
        link_port_a_err <= scen[1] ? 8'h01 : 8'h00;
        link_port_b_err <= scen[0] ? 8'h04 : 8'h00;
        link_ready <= scen[0] ? 8'h07 : 8'hFF;
        subunit_unreachable <= scen[0] ? 7'h7C : 7'h00;
    end
endmodule // cfs_link_model
`default_nettype wire

// file: channel_fault_status_bench.sv
// Self-checking bench for the channel fault status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(x, y) begin samples_checked++; if ((x) !== (y)) begin \
    failures++; $display("unexpected t=%0t got %h exp %h", $time, x, y); \
    end end
module channel_fault_status_bench import cfs_pkg::*;;
    typedef struct packed {
        logic [2:0] sc;
        logic [1:0] ct;
        logic [5:0] st;
        logic [6:0] ac;
        logic [15:0] sl;
    } cfs_row_t;
    // Scenario, control, status, access, unit 2 slot bitmap
    cfs_row_t rows [7] = '{
        '{3'h0, 2'h0, 6'h09, 7'h7F, 16'h0000},
        '{3'h1, 2'h0, 6'h2A, 7'h03, 16'h0020},
        '{3'h1, 2'h1, 6'h1A, 7'h03, 16'h0020},
        '{3'h1, 2'h2, 6'h1A, 7'h03, 16'h0020},
        '{3'h6, 2'h2, 6'h2C, 7'h7F, 16'h0000},
        '{3'h2, 2'h0, 6'h08, 7'h7F, 16'h0000},
        '{3'h0, 2'h3, 6'h09, 7'h7F, 16'h0000}};
    logic clk, arst_n, other_module_fault;
    logic [2:0] scen;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic loop_topology, chan_comm_lost, chan_primary_break;
    logic [127:0] link_slot_fault;
    logic [7:0] link_port_a_err, link_port_b_err, link_ready;
    logic [7:1] subunit_unreachable, subunit_access_enable;
    logic cpu_error_indicator, cpu_alarm_indicator, line_healthy_flag;
    logic comm_fault_flag, loop_switched_flag;
    logic notify_comm_fault, notify_switchover;
    logic [7:0] port_a_fault_indicator, port_b_fault_indicator;
    logic [7:0] link_ready_indicator;
    int failures = 0;
    int samples_checked = 0;
    cfs_channel_fault_status dut (.*);
    cfs_link_model link (.*);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic test_done();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // A wait that ran out is a mismatch and ends the run
    task automatic bound(input int n);
        if (n >= 40) begin
            failures++;
            test_done();
        end
    endtask
    // Slave ready is sampled before the edge's own updates land
    task automatic wr(input logic [7:0] a, input logic [31:0] v,
        input logic [1:0] er);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        s_axi_bready <= 1'b0;
        `CHK(s_axi_bresp, er)
        bound(n);
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er,
        output logic [31:0] v);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
        `CHK(s_axi_rresp, er)
        bound(n);
        @(posedge clk);
    endtask
    initial begin
        arst_n = 1'b0;
        scen = 3'h0;
        other_module_fault = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        // Each row sets the actions, then lets the link settle
        foreach (rows[i]) begin
            wr(CFS_CTRL_OFF, {30'h0, rows[i].ct}, CFS_RESP_OKAY);
            scen <= rows[i].sc;
            repeat (4) @(posedge clk);
            rd(CFS_STATUS_OFF, CFS_RESP_OKAY, d);
            `CHK(d, {26'h0, rows[i].st})
            rd(CFS_ACCESS_OFF, CFS_RESP_OKAY, d);
            `CHK(d, {24'h0, rows[i].ac, 1'b0})
            rd(CFS_SLOT_BASE + 8'h08, CFS_RESP_OKAY, d);
            `CHK(d, {16'h0, rows[i].sl})
        end
        rd(CFS_EVENT_OFF, CFS_RESP_OKAY, d);
        `CHK(d, 32'h3)
        wr(CFS_EVENT_OFF, 32'h3, CFS_RESP_OKAY);
        rd(CFS_EVENT_OFF, CFS_RESP_OKAY, d);
        `CHK(d, 32'h0)
        rd(CFS_LOG_OFF, CFS_RESP_OKAY, d);
        `CHK(d, 32'h202)
        // Read-only status ignores writes; holes and odd offsets refuse
        wr(CFS_STATUS_OFF, 32'hFF, CFS_RESP_OKAY);
        rd(CFS_STATUS_OFF, CFS_RESP_OKAY, d);
        `CHK(d, 32'h9)
        rd(8'h34, CFS_RESP_SLVERR, d);
        rd(8'h01, CFS_RESP_SLVERR, d);
        wr(8'h40, 32'h1, CFS_RESP_SLVERR);
        // Restart with subunits already lost: never established
        scen <= 3'h1;
        arst_n <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(CFS_CTRL_OFF, CFS_RESP_OKAY, d);
        `CHK(d, 32'h0)
        repeat (4) @(posedge clk);
        rd(CFS_STATUS_OFF, CFS_RESP_OKAY, d);
        `CHK(d, 32'h0)
        rd(CFS_SLOT_BASE + 8'h08, CFS_RESP_OKAY, d);
        `CHK(d, 32'h0)
        `CHK(port_b_fault_indicator, 8'h04)
        `CHK(link_ready_indicator, 8'h07)
        other_module_fault <= 1'b1;
        repeat (3) @(posedge clk);
        rd(CFS_STATUS_OFF, CFS_RESP_OKAY, d);
        `CHK(d, 32'h20)
        test_done();
    end
endmodule // channel_fault_status_bench
`default_nettype wire
